// file: core/pfdd_pkg.sv
// Contract
// R01: Mode 0 on an input does nothing
// R02: Mode 1: stop own, jump opposite, hold
// R03: Mode 2: stop own, run opposite, hold
// R04: Mode 3: stop own, opposite while fault
// R05: Mode 4: stop all, period kept
// R06: Mode 5: stop all, dead time during fault
// R07: Mode 6: stop all, advance, hold
// R08: Mode 7: stop all until software resumes
// R09: Mode 8: edge stops own, advance cycle
// R10: Mode 9: edge stops own, period kept
// R11: Mode 10: level stops own, period kept
// R12: Enable bits 7:4 gate pin drive
// R13: Value bits 3:0 give default levels
// R14: Defaults clear on power-on, else fuse load
// R15: Prescaler divides delay by 1,2,4,8
// R16: Delay starts on chosen compare event
// R17: Delay off, input blanking or event delay
// R18: Eight-bit delay in prescaled cycles
// R19: Dither target: on or dead time
// R20: Accumulate dither, stretch on overflow
// R21: Dither value double-buffered until update
// R22: Modes above 10 act as none
`default_nettype none
package pfdd_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_TRIG_A_MODE   = 8'h10;
	localparam logic [7:0] OFS_TRIG_B_MODE   = 8'h11;
	localparam logic [7:0] OFS_FAULT_DEFS    = 8'h12;
	localparam logic [7:0] OFS_DELAY_SETUP   = 8'h14;
	localparam logic [7:0] OFS_DELAY_COUNT   = 8'h15;
	localparam logic [7:0] OFS_DITHER_SEL    = 8'h18;
	localparam logic [7:0] OFS_DITHER_FRAC   = 8'h19;
	localparam logic [7:0] OFS_FAULT_STATUS  = 8'h1c;
	localparam logic [7:0] OFS_DITHER_ACC    = 8'h1d;
	localparam logic [7:0] OFS_HALT_CTRL     = 8'h1e;

	// ----------------------------------------
	// Reset values, fields and masks
	// ----------------------------------------
	localparam logic [7:0] RST_VALUE         = 8'h00;
	localparam logic [7:0] HALT_CTRL_MASK    = 8'h05;
	localparam int         FLT_EN_LSB        = 4;
	localparam int         DLY_PRESC_LSB     = 4;
	localparam int         DLY_TRIG_LSB      = 2;
	localparam int         DLY_SEL_LSB       = 0;
	localparam int         RESUME_BIT        = 0;

	// ----------------------------------------
	// Trigger response select codes
	// ----------------------------------------
	localparam logic [3:0] MODE_NONE                 = 4'h0;
	localparam logic [3:0] MODE_SKIP_TO_OPPOSITE_HOLD = 4'h1;
	localparam logic [3:0] MODE_RUN_OPPOSITE_HOLD    = 4'h2;
	localparam logic [3:0] MODE_RUN_OPPOSITE_FAULT   = 4'h3;
	localparam logic [3:0] MODE_STOP_ALL_KEEP_PERIOD = 4'h4;
	localparam logic [3:0] MODE_DEAD_TIME_FAULT      = 4'h5;
	localparam logic [3:0] MODE_STOP_ALL_ADVANCE     = 4'h6;
	localparam logic [3:0] MODE_STOP_ALL_UNTIL_SW    = 4'h7;
	localparam logic [3:0] MODE_EDGE_STOP_ADVANCE    = 4'h8;
	localparam logic [3:0] MODE_EDGE_STOP_KEEP       = 4'h9;
	localparam logic [3:0] MODE_LEVEL_STOP_KEEP      = 4'ha;

	// Delay function select and start source codes
	localparam logic [1:0] DLY_OFF           = 2'h0;
	localparam logic [1:0] DLY_INPUT_MASKING = 2'h1;
	localparam logic [1:0] DLY_EVENT         = 2'h2;
	localparam logic [1:0] SRC_A_RISE        = 2'h0;
	localparam logic [1:0] SRC_A_FALL        = 2'h1;
	localparam logic [1:0] SRC_B_RISE        = 2'h2;
	localparam logic [1:0] SRC_B_FALL        = 2'h3;

	// Dither target codes
	localparam logic [1:0] DIT_ACTIVE_B      = 2'h0;
	localparam logic [1:0] DIT_ACTIVE_BOTH   = 2'h1;
	localparam logic [1:0] DIT_GAP_B         = 2'h2;
	localparam logic [1:0] DIT_GAP_BOTH      = 2'h3;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {F_IDLE, F_HOLD, F_CYCLE, F_EXEC, F_SW} pfdd_fstate_t;

	typedef struct packed {
		logic a_set;
		logic a_clr;
		logic b_set;
		logic b_clr;
		logic cycle_end;
	} pfdd_cmp_evt_t;

	typedef struct packed {
		logic jump_opposite_a;
		logic jump_opposite_b;
		logic advance;
		logic run_opposite_a;
		logic run_opposite_b;
		logic dead_time_hold;
	} pfdd_core_req_t;

	typedef struct packed {
		logic on_a;
		logic on_b;
		logic dead_a;
		logic dead_b;
	} pfdd_dither_t;

	typedef struct packed {
		pfdd_fstate_t st;
		logic [3:0]   mode;
		logic         prev;
	} pfdd_fch_t;

endpackage
`default_nettype wire

// file: core/pfdd_core.sv
`timescale 1ns/1ns
`default_nettype none
module pfdd_core (
	// Clock and reset
	input  wire logic                    sys_clk,
	input  wire logic                    sys_rst,
	// Reset strap and fuse
	input  wire logic                    reset_was_power_on,
	input  wire logic [7:0]              timer_config_fuse,
	// Register port
	input  wire logic [7:0]              reg_addr,
	input  wire logic [7:0]              reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output var  logic [7:0]              reg_rdata,
	// Counter core side
	input  wire pfdd_pkg::pfdd_cmp_evt_t cmp_evt,
	input  wire logic                    update_cond,
	input  wire logic [3:0]              wave_in,
	input  wire logic [1:0]              trig_in,
	output var  pfdd_pkg::pfdd_core_req_t core_req,
	output var  pfdd_pkg::pfdd_dither_t  dither_stretch,
	output var  logic                    delayed_event,
	// Waveform pins
	output var  logic [3:0]              pin_out,
	output var  logic [3:0]              pin_oe_n
);
	import pfdd_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [1:0][3:0] in_mode;
		logic [7:0]      fault_defaults;
		logic            fuse_pending;
		logic [5:0]      delay_setup;
		logic [7:0]      delay_count;
		logic [1:0]      dither_sel;
		logic [3:0]      dither_buf;
		logic [3:0]      dither_active;
		logic [3:0]      dither_acc;
		logic [7:0]      halt_ctrl;
		logic            dly_run;
		logic [7:0]      dly_cnt;
		logic [2:0]      dly_pre;
		pfdd_fch_t       fch_a;
		pfdd_fch_t       fch_b;
		pfdd_core_req_t  req;
		pfdd_dither_t    dither;
		logic            dly_event;
		logic [7:0]      rdata;
		logic [3:0]      pin;
		logic [3:0]      oe_n;
	} pfdd_state_t;

	pfdd_state_t st;
	pfdd_state_t next_st;

	// Working signals of the combinational process
	pfdd_fch_t  cur_ch   [2];
	pfdd_fch_t  next_ch  [2];
	logic [1:0] start;
	logic [1:0] own_stop;
	logic       all_stop;
	logic       resume;
	logic       blank;
	logic       dly_tick;
	logic [4:0] dit_sum;
	logic [1:0] dly_sel;
	logic [1:0] dly_src;
	logic [1:0] dly_presc;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Mode stops only the output of its own input
	function automatic logic stops_own(input logic [3:0] m);
		begin
			stops_own = (m == MODE_SKIP_TO_OPPOSITE_HOLD) || (m == MODE_RUN_OPPOSITE_HOLD) ||
				(m == MODE_RUN_OPPOSITE_FAULT) || (m == MODE_EDGE_STOP_ADVANCE) ||
				(m == MODE_EDGE_STOP_KEEP) || (m == MODE_LEVEL_STOP_KEEP);
		end
	endfunction

	// Mode stops every output
	function automatic logic stops_all(input logic [3:0] m);
		begin
			stops_all = (m == MODE_STOP_ALL_KEEP_PERIOD) || (m == MODE_DEAD_TIME_FAULT) ||
				(m == MODE_STOP_ALL_ADVANCE) || (m == MODE_STOP_ALL_UNTIL_SW);
		end
	endfunction

	// Mode reacts to the level rather than the edge
	function automatic logic level_mode(input logic [3:0] m);
		begin
			level_mode = (m == MODE_RUN_OPPOSITE_FAULT) || (m == MODE_STOP_ALL_KEEP_PERIOD) ||
				(m == MODE_DEAD_TIME_FAULT) || (m == MODE_LEVEL_STOP_KEEP);
		end
	endfunction

	// One step of a fault channel
	function automatic pfdd_fch_t fault_step(input pfdd_fch_t ch, input logic [3:0] m,
		input logic trig, input logic mask, input logic cyc_end, input logic sw_go);
		pfdd_fch_t n;
		logic      hit;
		begin
			n      = ch;
			n.prev = trig;
			hit    = !mask && (level_mode(m) ? trig : (trig && !ch.prev));
			case (ch.st)
				F_IDLE:
				begin
					if (hit)
					begin
						n.mode = m;
						case (m)
							MODE_SKIP_TO_OPPOSITE_HOLD: n.st = F_HOLD;   // [R02]
							MODE_RUN_OPPOSITE_HOLD:     n.st = F_EXEC;   // [R03]
							MODE_RUN_OPPOSITE_FAULT:    n.st = F_HOLD;   // [R04]
							MODE_STOP_ALL_KEEP_PERIOD:  n.st = F_HOLD;   // [R05]
							MODE_DEAD_TIME_FAULT:       n.st = F_HOLD;   // [R06]
							MODE_STOP_ALL_ADVANCE:      n.st = F_HOLD;   // [R07]
							MODE_STOP_ALL_UNTIL_SW:     n.st = F_SW;     // [R08]
							MODE_EDGE_STOP_ADVANCE:     n.st = F_CYCLE;  // [R09]
							MODE_EDGE_STOP_KEEP:        n.st = F_CYCLE;  // [R10]
							MODE_LEVEL_STOP_KEEP:       n.st = F_HOLD;   // [R11]
							default:                    n.st = F_IDLE;   // [R01] [R22]
						endcase
					end
				end
				F_HOLD:
				begin
					if (!trig)
						n.st = F_IDLE;
				end
				F_CYCLE:
				begin
					if (cyc_end)
						n.st = F_IDLE;
				end
				F_EXEC:
				begin
					if (cyc_end)
						n.st = F_HOLD;
				end
				F_SW:
				begin
					if (sw_go)
						n.st = F_IDLE;  // [R08]
				end
				default:
					n.st = F_IDLE;
			endcase
			fault_step = n;
		end
	endfunction

	// Prescaler terminal count
	function automatic logic [2:0] presc_limit(input logic [1:0] p);
		begin
			case (p)
				2'h0:    presc_limit = 3'h0;
				2'h1:    presc_limit = 3'h1;
				2'h2:    presc_limit = 3'h3;
				default: presc_limit = 3'h7;
			endcase
		end
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		next_st       = st;
		next_st.rdata = RST_VALUE;
		next_st.req   = '0;
		next_st.dly_event = 1'b0;
		resume        = 1'b0;
		dly_sel   = st.delay_setup[DLY_SEL_LSB +: 2];
		dly_src   = st.delay_setup[DLY_TRIG_LSB +: 2];
		dly_presc = st.delay_setup[DLY_PRESC_LSB +: 2];

		// Fuse load in the first cycle after a non power-on reset
		if (st.fuse_pending)
		begin
			next_st.fuse_pending = 1'b0;
			if (!reset_was_power_on)
				next_st.fault_defaults = timer_config_fuse;  // [R14]
		end

		// Register writes
		if (reg_wr)
		begin
			if (reg_addr == OFS_TRIG_A_MODE)
				next_st.in_mode[0] = reg_wdata[3:0];
			else if (reg_addr == OFS_TRIG_B_MODE)
				next_st.in_mode[1] = reg_wdata[3:0];
			else if (reg_addr == OFS_FAULT_DEFS)
				next_st.fault_defaults = reg_wdata;
			else if (reg_addr == OFS_DELAY_SETUP)
				next_st.delay_setup = reg_wdata[5:0];
			else if (reg_addr == OFS_DELAY_COUNT)
				next_st.delay_count = reg_wdata;
			else if (reg_addr == OFS_DITHER_SEL)
				next_st.dither_sel = reg_wdata[1:0];
			else if (reg_addr == OFS_DITHER_FRAC)
				next_st.dither_buf = reg_wdata[3:0];  // [R21]
			else if (reg_addr == OFS_FAULT_STATUS)
				resume = reg_wdata[RESUME_BIT];  // [R08]
			else if (reg_addr == OFS_HALT_CTRL)
				next_st.halt_ctrl = reg_wdata & HALT_CTRL_MASK;
		end

		// Register reads, data stand one cycle later
		if (reg_rd)
		begin
			if (reg_addr == OFS_TRIG_A_MODE)
				next_st.rdata = {4'h0, st.in_mode[0]};
			else if (reg_addr == OFS_TRIG_B_MODE)
				next_st.rdata = {4'h0, st.in_mode[1]};
			else if (reg_addr == OFS_FAULT_DEFS)
				next_st.rdata = st.fault_defaults;
			else if (reg_addr == OFS_DELAY_SETUP)
				next_st.rdata = {2'h0, st.delay_setup};
			else if (reg_addr == OFS_DELAY_COUNT)
				next_st.rdata = st.delay_count;
			else if (reg_addr == OFS_DITHER_SEL)
				next_st.rdata = {6'h00, st.dither_sel};
			else if (reg_addr == OFS_DITHER_FRAC)
				next_st.rdata = {4'h0, st.dither_buf};
			else if (reg_addr == OFS_FAULT_STATUS)
				next_st.rdata = {3'h0, st.dly_run, (st.fch_b.st == F_SW),
					(st.fch_a.st == F_SW), (st.fch_b.st != F_IDLE),
					(st.fch_a.st != F_IDLE)};
			else if (reg_addr == OFS_DITHER_ACC)
				next_st.rdata = {4'h0, st.dither_acc};
			else if (reg_addr == OFS_HALT_CTRL)
				next_st.rdata = st.halt_ctrl;
		end

		// Delay unit: start, prescale, count down
		blank    = st.dly_run && (dly_sel == DLY_INPUT_MASKING);  // [R17]
		dly_tick = (st.dly_pre == presc_limit(dly_presc));  // [R15]
		if (st.dly_run)
		begin
			if (st.dly_cnt == 8'h00)
			begin
				next_st.dly_run   = 1'b0;
				next_st.dly_event = (dly_sel == DLY_EVENT);  // [R17]
			end
			else if (dly_tick)
			begin
				next_st.dly_cnt = st.dly_cnt - 8'h01;  // [R18]
				next_st.dly_pre = 3'h0;
			end
			else
				next_st.dly_pre = st.dly_pre + 3'h1;
		end
		else if ((dly_sel == DLY_INPUT_MASKING) || (dly_sel == DLY_EVENT))
		begin
			// Start source select
			if (((dly_src == SRC_A_RISE) && cmp_evt.a_set) ||
				((dly_src == SRC_A_FALL) && cmp_evt.a_clr) ||
				((dly_src == SRC_B_RISE) && cmp_evt.b_set) ||
				((dly_src == SRC_B_FALL) && cmp_evt.b_clr))  // [R16]
			begin
				next_st.dly_run = 1'b1;
				next_st.dly_cnt = st.delay_count;  // [R18]
				next_st.dly_pre = 3'h0;
			end
		end

		// Fault channels, one per trigger input
		cur_ch[0] = st.fch_a;
		cur_ch[1] = st.fch_b;
		for (int i = 0; i < 2; i++)
		begin
			next_ch[i]  = fault_step(cur_ch[i], st.in_mode[i], trig_in[i], blank,
				cmp_evt.cycle_end, resume);
			start[i]    = (cur_ch[i].st == F_IDLE) && (next_ch[i].st != F_IDLE);
			own_stop[i] = (cur_ch[i].st != F_IDLE) && stops_own(cur_ch[i].mode);
		end
		next_st.fch_a = next_ch[0];
		next_st.fch_b = next_ch[1];
		all_stop = ((st.fch_a.st != F_IDLE) && stops_all(st.fch_a.mode)) ||
			((st.fch_b.st != F_IDLE) && stops_all(st.fch_b.mode));

		// Requests to the counter core
		next_st.req.jump_opposite_a = start[0] &&
			(next_ch[0].mode == MODE_SKIP_TO_OPPOSITE_HOLD);  // [R02]
		next_st.req.jump_opposite_b = start[1] &&
			(next_ch[1].mode == MODE_SKIP_TO_OPPOSITE_HOLD);  // [R02]
		next_st.req.advance = (start[0] && ((next_ch[0].mode == MODE_STOP_ALL_ADVANCE) ||
			(next_ch[0].mode == MODE_EDGE_STOP_ADVANCE))) ||
			(start[1] && ((next_ch[1].mode == MODE_STOP_ALL_ADVANCE) ||
			(next_ch[1].mode == MODE_EDGE_STOP_ADVANCE)));  // [R07] [R09]
		next_st.req.run_opposite_a = (next_ch[0].st == F_EXEC) ||
			((next_ch[0].st == F_HOLD) && (next_ch[0].mode == MODE_RUN_OPPOSITE_FAULT));  // [R03] [R04]
		next_st.req.run_opposite_b = (next_ch[1].st == F_EXEC) ||
			((next_ch[1].st == F_HOLD) && (next_ch[1].mode == MODE_RUN_OPPOSITE_FAULT));  // [R03] [R04]
		next_st.req.dead_time_hold =
			((next_ch[0].st != F_IDLE) && (next_ch[0].mode == MODE_DEAD_TIME_FAULT)) ||
			((next_ch[1].st != F_IDLE) && (next_ch[1].mode == MODE_DEAD_TIME_FAULT));  // [R06]

		// Dither: buffer copy, accumulate at cycle end
		if (update_cond)
			next_st.dither_active = st.dither_buf;  // [R21]
		dit_sum = {1'b0, st.dither_acc} + {1'b0, st.dither_active};
		if (cmp_evt.cycle_end)
		begin
			next_st.dither_acc = dit_sum[3:0];  // [R20]
			next_st.dither     = '0;
			if (dit_sum[4])
			begin
				case (st.dither_sel)
					DIT_ACTIVE_B:    next_st.dither.on_b = 1'b1;  // [R19]
					DIT_ACTIVE_BOTH:
					begin
						next_st.dither.on_a = 1'b1;
						next_st.dither.on_b = 1'b1;
					end
					DIT_GAP_B:       next_st.dither.dead_b = 1'b1;
					default:
					begin
						next_st.dither.dead_a = 1'b1;
						next_st.dither.dead_b = 1'b1;
					end
				endcase
			end
		end

		// Pin levels and drive enables
		for (int k = 0; k < 4; k++)
		begin
			if (all_stop || ((k < 2) && own_stop[k[0]]))
				next_st.pin[k] = st.fault_defaults[k];  // [R13]
			else
				next_st.pin[k] = wave_in[k];
			next_st.oe_n[k] = !st.fault_defaults[FLT_EN_LSB + k];  // [R12]
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st              <= '0;
			st.fuse_pending <= 1'b1;
			st.oe_n         <= 4'hf;  // [R12]
		end
		else
			st <= next_st;
	end

	// Outputs straight from the state register
	assign reg_rdata      = st.rdata;
	assign core_req       = st.req;
	assign dither_stretch = st.dither;
	assign delayed_event  = st.dly_event;
	assign pin_out        = st.pin;
	assign pin_oe_n       = st.oe_n;

endmodule
`default_nettype wire

// file: tb/pfdd_partner.sv
`timescale 1ns/1ns
`default_nettype none
module pfdd_partner (
	// Clock and reset
	input	wire logic			sys_clk,
	input	wire logic			sys_rst,
	// Counter core side
	output	var pfdd_pkg::pfdd_cmp_evt_t	cmp_evt,
	output	var logic [3:0]			wave_in
);
	import pfdd_pkg::*;
	logic [3:0]	cnt;
	// Sixteen-step timer cycle
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			cnt <= 4'h0;
		else
			cnt <= cnt + 4'h1;
	end
	// Compare points and waveform levels, low in the first half
	always_comb
	begin
		cmp_evt.a_set = (cnt == 4'h1);
		cmp_evt.a_clr = (cnt == 4'h5);
		cmp_evt.b_set = (cnt == 4'h8);
		cmp_evt.b_clr = (cnt == 4'hc);
		cmp_evt.cycle_end = (cnt == 4'hf);
		wave_in = {4{cnt[3]}};
	end
endmodule
`default_nettype wire

// file: tb/pfdd_core_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module pfdd_core_assertions (
	// Clock, reset, fuse
	input	wire logic			sys_clk,
	input	wire logic			sys_rst,
	input	wire logic			reset_was_power_on,
	input	wire logic [7:0]		timer_config_fuse,
	// Register port
	input	wire logic [7:0]		reg_addr,
	input	wire logic [7:0]		reg_wdata,
	input	wire logic			reg_wr,
	input	wire logic			reg_rd,
	input	wire logic [7:0]		reg_rdata,
	// Core side and pins
	input	wire logic [1:0]		trig_in,
	input	wire pfdd_pkg::pfdd_core_req_t	core_req,
	input	wire logic			delayed_event,
	input	wire logic [3:0]		pin_out,
	input	wire logic [3:0]		pin_oe_n
);
	import pfdd_pkg::*;
	logic		first;
	logic [3:0]	mode_a;
	logic [7:0]	dfl;
	logic [1:0]	dly_fn;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	// Shadow copies of the registers the properties lean on
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			first <= 1'b1;
			mode_a <= 4'h0;
			dly_fn <= 2'h0;
		end
		else
		begin
			first <= 1'b0;
			if (first)
				dfl <= reset_was_power_on ? 8'h00 : timer_config_fuse;
			if (reg_wr && reg_addr == OFS_FAULT_DEFS)
				dfl <= reg_wdata;
			if (reg_wr && reg_addr == OFS_TRIG_A_MODE)
				mode_a <= reg_wdata[3:0];
			if (reg_wr && reg_addr == OFS_DELAY_SETUP)
				dly_fn <= reg_wdata[1:0];
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	a_oe_follow: assert property (reg_wr && reg_addr == OFS_FAULT_DEFS
		|-> ##2 pin_oe_n == ~dfl[7:4]) else $error("pin enable mismatch");
	a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside slot");
	a_rd_back: assert property (reg_wr && reg_addr == OFS_DELAY_COUNT
		##2 reg_rd && reg_addr == OFS_DELAY_COUNT |=> reg_rdata == $past(reg_wdata, 3))
		else $error("delay count readback");
	a_quiet_mode: assert property ((mode_a == 4'h0 || mode_a > 4'ha)[*4]
		|-> core_req == '0) else $error("request in quiet mode");
	a_edge_adv: assert property (mode_a == 4'h8 && dly_fn == 2'h0 && $rose(trig_in[0])
		|-> ##[1:2] core_req.advance) else $error("no advance on edge");
	a_level_pin: assert property ((mode_a == 4'ha && dly_fn == 2'h0 && trig_in[0])[*4]
		|-> pin_out[0] == dfl[0]) else $error("level stop pin");
	a_all_stop: assert property ((mode_a == 4'h4 && dly_fn == 2'h0 && trig_in[0])[*4]
		|-> pin_out == dfl[3:0]) else $error("all stop pins");
	a_evt_pulse: assert property (delayed_event |=> !delayed_event)
		else $error("delayed event too long");
	a_evt_func: assert property (delayed_event |-> dly_fn == DLY_EVENT)
		else $error("delayed event without event delay");
	a_jump_pulse: assert property (core_req.jump_opposite_a |=> !core_req.jump_opposite_a)
		else $error("jump request too long");
endmodule
bind pfdd_core pfdd_core_assertions pfdd_core_assertions_inst (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .reset_was_power_on(reset_was_power_on),
	.timer_config_fuse(timer_config_fuse), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_in(trig_in),
	.core_req(core_req), .delayed_event(delayed_event), .pin_out(pin_out),
	.pin_oe_n(pin_oe_n)
);
`default_nettype wire

// file: tb/pfdd_core_bench.sv
`timescale 1ns/1ns
`default_nettype none
module pfdd_core_bench;
	import pfdd_pkg::*;
	logic			sys_clk = 1'b0;
	logic			sys_rst = 1'b1;
	logic			por = 1'b1;
	logic			ch_b = 1'b0;
	logic [7:0]		fuse = 8'h00;
	logic [7:0]		reg_addr = 8'h00;
	logic [7:0]		reg_wdata = 8'h00;
	logic			reg_wr = 1'b0;
	logic			reg_rd = 1'b0;
	logic			update_cond = 1'b0;
	logic [1:0]		trig_in = 2'h0;
	logic [7:0]		reg_rdata;
	logic [3:0]		wave_in;
	logic [3:0]		pin_out;
	logic [3:0]		pin_oe_n;
	logic [3:0]		dsee;
	logic [5:0]		seen;
	logic			delayed_event;
	pfdd_cmp_evt_t		cmp_evt;
	pfdd_core_req_t		core_req;
	pfdd_dither_t		dither_stretch;
	logic [7:0]		offs [8] = '{8'h10, 8'h11, 8'h12, 8'h14, 8'h15, 8'h18, 8'h19, 8'h1e};
	logic [15:0]		dtab = 16'h31c4;
	int			n_mismatch = 0;
	int			cmp_count = 0;
	int			i;
	int			n;
	pfdd_core pfdd_core_inst (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .reset_was_power_on(por),
		.timer_config_fuse(fuse), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_evt(cmp_evt),
		.update_cond(update_cond), .wave_in(wave_in), .trig_in(trig_in),
		.core_req(core_req), .dither_stretch(dither_stretch),
		.delayed_event(delayed_event), .pin_out(pin_out), .pin_oe_n(pin_oe_n)
	);
	pfdd_partner pfdd_partner_inst (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .cmp_evt(cmp_evt), .wave_in(wave_in)
	);
	// Clock
	always #5 sys_clk = ~sys_clk;
	// Compare and count
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Counts and verdict
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Register bus cycles
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk("rdata", reg_rdata, e);
	endtask
	// Bounded wait for one compare event bit
	task automatic wait_evt(input int k);
		for (int j = 0; j < 40; j++)
		begin
			@(posedge sys_clk);
			#1;
			if (cmp_evt[k])
				return;
		end
		chk("event wait", 8'h01, 8'h00);
		print_verdict();
	endtask
	// Trigger input A, or input B when ch_b is set, in one mode, check requests, pins and status
	task automatic fault(input logic [3:0] m, input logic [5:0] rq, input logic [7:0] st,
		input logic [3:0] pe);
		wr(ch_b ? OFS_TRIG_B_MODE : OFS_TRIG_A_MODE, {4'h0, m});
		wait_evt(0);
		@(posedge sys_clk);
		trig_in <= ch_b ? 2'h2 : 2'h1;
		seen = '0;
		repeat (4)
		begin
			@(posedge sys_clk);
			#1 seen = seen | core_req;
		end
		chk("core_req", {2'h0, seen}, {2'h0, rq});
		chk("pin_out", {4'h0, pin_out}, {4'h0, pe});
		rd(OFS_FAULT_STATUS, st);
		@(posedge sys_clk);
		trig_in <= 2'h0;
		if (m == MODE_STOP_ALL_UNTIL_SW)
		begin
			rd(OFS_FAULT_STATUS, st);
			wr(OFS_FAULT_STATUS, 8'h01);
		end
		wait_evt(0);
		repeat (4) @(posedge sys_clk);
		rd(OFS_FAULT_STATUS, 8'h00);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (20) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		for (i = 0; i < 8; i++)
			rd(offs[i], 8'h00);
		rd(8'h13, 8'h00);
		wr(OFS_TRIG_A_MODE, 8'hff);
		rd(OFS_TRIG_A_MODE, 8'h0f);
		wr(OFS_HALT_CTRL, 8'hff);
		rd(OFS_HALT_CTRL, 8'h05);
		wr(OFS_DELAY_COUNT, 8'ha5);
		rd(OFS_DELAY_COUNT, 8'ha5);
		wr(OFS_FAULT_DEFS, 8'h35);
		rd(OFS_FAULT_DEFS, 8'h35);
		chk("pin_oe_n", {4'h0, pin_oe_n}, 8'h0c);
		fault(4'h0, 6'h00, 8'h00, 4'h0);
		for (i = 11; i < 16; i++)
			fault(i[3:0], 6'h00, 8'h00, 4'h0);
		fault(4'h1, 6'h20, 8'h01, 4'h1);
		fault(4'h2, 6'h04, 8'h01, 4'h1);
		fault(4'h3, 6'h04, 8'h01, 4'h1);
		fault(4'h4, 6'h00, 8'h01, 4'h5);
		fault(4'h5, 6'h01, 8'h01, 4'h5);
		fault(4'h6, 6'h08, 8'h01, 4'h5);
		fault(4'h7, 6'h00, 8'h05, 4'h5);
		fault(4'h8, 6'h08, 8'h01, 4'h1);
		fault(4'h9, 6'h00, 8'h01, 4'h1);
		fault(4'ha, 6'h00, 8'h01, 4'h1);
		// Input B stops only its own output
		wr(OFS_FAULT_DEFS, 8'h37);
		ch_b = 1'b1;
		fault(4'h1, 6'h10, 8'h02, 4'h2);
		fault(4'h3, 6'h02, 8'h02, 4'h2);
		ch_b = 1'b0;
		// Event delay: each divider, paired with the start source of the same code
		wr(OFS_DELAY_COUNT, 8'h03);
		for (i = 0; i < 4; i++)
		begin
			wr(OFS_DELAY_SETUP, {2'h0, i[1:0], i[1:0], DLY_EVENT});
			wait_evt(4 - i);
			n = 0;
			while (delayed_event !== 1'b1 && n < 60)
			begin
				@(posedge sys_clk);
				#1 n++;
			end
			chk("delay", {7'h0, n >= (3 << i) && n <= (3 << i) + 3}, 8'h01);
			if (n >= 60)
				print_verdict();
		end
		// Input masking hides a level trigger for its run
		wr(OFS_DELAY_COUNT, 8'h10);
		wr(OFS_DELAY_SETUP, 8'h01);
		wait_evt(4);
		@(posedge sys_clk);
		trig_in <= 2'h1;
		rd(OFS_FAULT_STATUS, 8'h10);
		repeat (18) @(posedge sys_clk);
		rd(OFS_FAULT_STATUS, 8'h01);
		@(posedge sys_clk);
		trig_in <= 2'h0;
		// Dither: buffered value, then each target
		wr(OFS_DITHER_FRAC, 8'h08);
		wait_evt(0);
		repeat (2) @(posedge sys_clk);
		rd(OFS_DITHER_ACC, 8'h00);
		@(posedge sys_clk);
		update_cond <= 1'b1;
		@(posedge sys_clk);
		update_cond <= 1'b0;
		for (i = 0; i < 4; i++)
		begin
			wr(OFS_DITHER_SEL, i[7:0]);
			wait_evt(0);
			repeat (2) @(posedge sys_clk);
			dsee = '0;
			repeat (34)
			begin
				@(posedge sys_clk);
				#1 dsee = dsee | dither_stretch;
			end
			chk("dither", {4'h0, dsee}, {4'h0, dtab[i*4 +: 4]});
		end
		// Second reset that is not power-on loads the fuse
		@(posedge sys_clk);
		por <= 1'b0;
		fuse <= 8'h5a;
		sys_rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk("pin_oe_n", {4'h0, pin_oe_n}, 8'h0f);
		sys_rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rd(OFS_FAULT_DEFS, 8'h5a);
		chk("pin_oe_n", {4'h0, pin_oe_n}, 8'h0a);
		print_verdict();
	end
endmodule
`default_nettype wire
